// ===== core/caae_pkg.sv
// shared constants and types for the table entry aging engine
package caae_pkg;
   // host register selects, 32-bit mode (select bit 0 ignored)
   localparam logic [4:0]  CAAE_SEL_CONFIG   = 5'h10;        // configuration register
   localparam logic [4:0]  CAAE_SEL_INTERVAL = 5'h18;        // aging interval register
   localparam logic [4:0]  CAAE_SEL_LIFE     = 5'h19;        // entry life register
   localparam logic [4:0]  CAAE_SEL_AGECMD   = 5'h1a;        // manual age command (write only)
   // configuration field positions
   localparam int          CAAE_CFG_AUTO_BIT = 13;           // automatic aging enable
   localparam int          CAAE_CFG_PRIO_BIT = 18;           // aging beats both ports
   // widths
   localparam int          CAAE_LIFE_W       = 9;            // entry life count width
   localparam int          CAAE_IDX_W        = 8;            // entry index width in carriers
   // values after reset
   localparam logic [31:0] CAAE_CONFIG_RST   = 32'h0000_0000; // configuration
   localparam logic [31:0] CAAE_INTERVAL_RST = 32'h02fa_f080; // one second at 50 MHz
   localparam logic [8:0]  CAAE_LIFE_RST     = 9'h12c;       // 300 intervals

   // one host register access, same clock as the engine
   typedef struct packed {
      logic                  cs;     // access strobe
      logic                  write;  // 1 write, 0 read
      logic [5:0]            regSel; // host_register_select
      logic [31:0]           wrData; // write data
   } caae_host_req_t;

   // one table operation from the synchronous or processor port
   typedef struct packed {
      logic                  req;    // held until granted
      logic                  learn;  // 1 learn, 0 search with aging
      logic                  perm;   // learned entry is permanent
      logic [CAAE_IDX_W-1:0] idx;    // entry matched or added
   } caae_port_req_t;
endpackage : caae_pkg

// ===== core/caae_life_cell.sv
// one table entry: valid, permanent mark and remaining life
`timescale 1ns/100ps
module caae_life_cell
   import caae_pkg::*;
(
   input  wire logic                   core_clk, // system clock
   input  wire logic                   rst,      // sync reset, active high
   input  wire logic                   learn,    // add entry now
   input  wire logic                   touch,    // refresh stamp now
   input  wire logic                   permIn,   // permanent mark on learn
   input  wire logic [CAAE_LIFE_W-1:0] lifeLoad, // full programmed life
   input  wire logic                   tick,     // interval expiry
   input  wire logic                   purge,    // manual age pass
   input  wire logic [CAAE_LIFE_W-1:0] minLife,  // oldest life in table
   output logic                        valid_r,  // entry holds data
   output logic                        perm_r,   // entry is permanent
   output logic [CAAE_LIFE_W-1:0]      life_r    // remaining life, internal only
);
   logic                   valid_nxt; // next valid
   logic                   perm_nxt;  // next permanent mark
   logic [CAAE_LIFE_W-1:0] life_nxt;  // next life
   logic                   ageable;   // aging may act on it

   // next entry state; arbiter keeps load, tick and purge apart
   always_comb begin
      valid_nxt = valid_r;
      perm_nxt  = perm_r;
      life_nxt  = life_r;
      ageable   = valid_r && !perm_r;
      if (learn) begin
         valid_nxt = 1'b1;
         perm_nxt  = permIn;
         life_nxt  = lifeLoad;
      end else if (touch && valid_r) begin
         life_nxt = lifeLoad;
      end else if (tick && ageable) begin
         if (life_r <= 9'h001) begin
            valid_nxt = 1'b0;
            life_nxt  = 9'h000;
         end else begin
            life_nxt = life_r - 9'h001;
         end
      end else if (purge && ageable && life_r == minLife) begin
         valid_nxt = 1'b0;
      end
   end

   // entry flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         valid_r <= 1'b0;
         perm_r  <= 1'b0;
         life_r  <= 9'h000;
      end else begin
         valid_r <= valid_nxt;
         perm_r  <= perm_nxt;
         life_r  <= life_nxt;
      end
   end

   property p_permKeep;
      @(posedge core_clk) disable iff (rst)
      (valid_r && perm_r && !learn) |=> (valid_r && perm_r);
   endproperty
   a_permKeep: assert property (p_permKeep) else $error("permanent entry lost");

   property p_refresh;
      @(posedge core_clk) disable iff (rst)
      ((touch && valid_r) || learn) |=> (life_r == $past(lifeLoad));
   endproperty
   a_refresh: assert property (p_refresh) else $error("life not restarted");

   property p_tick;
      @(posedge core_clk) disable iff (rst)
      (tick && !learn && !touch && valid_r && !perm_r && life_r > 9'h001)
         |=> (valid_r && life_r == $past(life_r) - 9'h001);
   endproperty
   a_tick: assert property (p_tick) else $error("life not decremented");
endmodule : caae_life_cell

// ===== core/caae_aging_engine.sv
// table entry aging engine: registers, interval timer, arbiter, entries
// Functional notes
// - automatic purges triggered only while config bit 13 set; a pending one still runs after it clears
// - purge removes oldest stamps, never permanent entries
// - manual age works with automatic aging off
// - interval register counts clocks between purges
// - interval register resets to half a second at 100 MHz
// - config bit 18 gives aging top precedence
// - entry life register is nine bits
// - touched entry restarts at full life
// - entry life register resets to 300
// - search with aging and learn refresh stamps
// - time stamps never readable
// - configuration written only from host port
`timescale 1ns/100ps
module caae_aging_engine
   import caae_pkg::*;
#(
   parameter int                 ENTRIES      = 16,               // table depth
   parameter logic [31:0]        INTERVAL_RST = CAAE_INTERVAL_RST // interval after reset
) (
   input  wire logic                 core_clk,      // system clock, 100 MHz
   input  wire logic                 rst,           // sync reset, active high
   input  wire caae_pkg::caae_host_req_t hostReq,   // host register access
   output logic [31:0]               hostRdData_r,  // host read data
   output logic                      hostPortReady_r, // access done pulse
   input  wire caae_pkg::caae_port_req_t portReq,   // table operation request
   output logic                      portGrant_r,   // operation taken pulse
   output logic                      purgeDone_r,   // aging pass done pulse
   output logic [ENTRIES-1:0]        entryValid_r   // per-entry valid
);
   import caae_pkg::*;

   logic [31:0]            cfgReg_r;       // configuration register
   logic [31:0]            cfgReg_nxt;     // next configuration
   logic [31:0]            intervalReg_r;  // aging interval register
   logic [31:0]            intervalReg_nxt;
   logic [CAAE_LIFE_W-1:0] lifeReg_r;      // entry life register
   logic [CAAE_LIFE_W-1:0] lifeReg_nxt;
   logic [31:0]            intervalCnt_r;  // clocks left in interval
   logic [31:0]            intervalCnt_nxt;
   logic                   autoPend_r;     // automatic purge waiting
   logic                   autoPend_nxt;
   logic                   manPend_r;      // manual age waiting
   logic                   manPend_nxt;
   logic [31:0]            hostRdData_nxt;
   logic                   hostPortReady_nxt;
   logic                   portGrant_nxt;
   logic                   purgeDone_nxt;
   logic                   hostWr;         // host write this cycle
   logic [4:0]             hostSel;        // word select
   logic                   autoEn;         // automatic aging on
   logic                   expiry;         // interval ends this cycle
   logic                   agePend;        // any aging op waiting
   logic                   agingWins;      // aging owns the array now
   logic                   portTake;       // port op runs now
   logic                   doAuto;         // automatic pass runs now
   logic                   doManual;       // manual pass runs now
   logic [CAAE_LIFE_W-1:0] minLife;        // oldest life among ageable
   logic [ENTRIES-1:0]     permVec;        // permanent marks
   logic [CAAE_LIFE_W-1:0] lifeVec [ENTRIES]; // lives, internal only

   assign hostWr  = hostReq.cs && hostReq.write;
   assign hostSel = hostReq.regSel[5:1];
   assign autoEn  = cfgReg_r[CAAE_CFG_AUTO_BIT];

   // register writes; only the host port reaches these flops
   always_comb begin
      cfgReg_nxt      = cfgReg_r;
      intervalReg_nxt = intervalReg_r;
      lifeReg_nxt     = lifeReg_r;
      if (hostWr) begin
         unique case (hostSel)
            CAAE_SEL_CONFIG:   cfgReg_nxt      = hostReq.wrData;
            CAAE_SEL_INTERVAL: intervalReg_nxt = hostReq.wrData;
            CAAE_SEL_LIFE:     lifeReg_nxt     = hostReq.wrData[CAAE_LIFE_W-1:0];
            default: ;         // age command or unmapped: nothing stored
         endcase
      end
   end

   // host read path and ready pulse
   always_comb begin
      hostRdData_nxt    = 32'h0000_0000;
      hostPortReady_nxt = hostReq.cs;
      if (hostReq.cs && !hostReq.write) begin
         unique case (hostSel)
            CAAE_SEL_CONFIG:   hostRdData_nxt = cfgReg_r;
            CAAE_SEL_INTERVAL: hostRdData_nxt = intervalReg_r;
            CAAE_SEL_LIFE:     hostRdData_nxt = {23'h000000, lifeReg_r};
            default:           hostRdData_nxt = 32'h0000_0000;
         endcase
      end
   end

   // interval timer; an interval of zero behaves as one clock
   always_comb begin
      intervalCnt_nxt = intervalCnt_r;
      expiry          = 1'b0;
      if (!autoEn) begin
         intervalCnt_nxt = intervalReg_r;
      end else if (intervalCnt_r <= 32'h0000_0001) begin
         expiry          = 1'b1;
         intervalCnt_nxt = intervalReg_r;
      end else begin
         intervalCnt_nxt = intervalCnt_r - 32'h0000_0001;
      end
   end

   // oldest remaining life among non-permanent valid entries
   always_comb begin
      minLife = {CAAE_LIFE_W{1'b1}};
      for (int i = 0; i < ENTRIES; i++) begin
         if (entryValid_r[i] && !permVec[i] && lifeVec[i] < minLife) begin
            minLife = lifeVec[i];
         end
      end
   end

   // arbitration between aging and the ports
   always_comb begin
      agePend   = autoPend_r || manPend_r;
      agingWins = agePend && (cfgReg_r[CAAE_CFG_PRIO_BIT] || !portReq.req);
      portTake  = portReq.req && !agingWins && !portGrant_r;
      doAuto    = agingWins && autoPend_r;
      doManual  = agingWins && !autoPend_r && manPend_r;
   end

   // pending aging work; a new event wins over the clear
   always_comb begin
      autoPend_nxt  = expiry || (autoPend_r && !doAuto);
      manPend_nxt   = (hostWr && hostSel == CAAE_SEL_AGECMD) || (manPend_r && !doManual);
      portGrant_nxt = portTake;
      purgeDone_nxt = doAuto || doManual;
   end

   // engine flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfgReg_r        <= CAAE_CONFIG_RST;
         intervalReg_r   <= INTERVAL_RST;
         lifeReg_r       <= CAAE_LIFE_RST;
         intervalCnt_r   <= INTERVAL_RST;
         autoPend_r      <= 1'b0;
         manPend_r       <= 1'b0;
         hostRdData_r    <= 32'h0000_0000;
         hostPortReady_r <= 1'b0;
         portGrant_r     <= 1'b0;
         purgeDone_r     <= 1'b0;
      end else begin
         cfgReg_r        <= cfgReg_nxt;
         intervalReg_r   <= intervalReg_nxt;
         lifeReg_r       <= lifeReg_nxt;
         intervalCnt_r   <= intervalCnt_nxt;
         autoPend_r      <= autoPend_nxt;
         manPend_r       <= manPend_nxt;
         hostRdData_r    <= hostRdData_nxt;
         hostPortReady_r <= hostPortReady_nxt;
         portGrant_r     <= portGrant_nxt;
         purgeDone_r     <= purgeDone_nxt;
      end
   end

   // one cell per entry
   for (genvar g = 0; g < ENTRIES; g++) begin : gEntry
      logic hit; // port op targets this entry
      assign hit = portTake && (portReq.idx == CAAE_IDX_W'(g));
      caae_life_cell uCell (
         .core_clk (core_clk),
         .rst      (rst),
         .learn    (hit && portReq.learn),
         .touch    (hit && !portReq.learn),
         .permIn   (portReq.perm),
         .lifeLoad (lifeReg_r),
         .tick     (doAuto),
         .purge    (doManual),
         .minLife  (minLife),
         .valid_r  (entryValid_r[g]),
         .perm_r   (permVec[g]),
         .life_r   (lifeVec[g])
      );
   end

   property p_autoOff;
      @(posedge core_clk) disable iff (rst)
      (!autoEn && !autoPend_r) |=> !autoPend_r;
   endproperty
   a_autoOff: assert property (p_autoOff) else $error("purge while auto off");

   property p_manual;
      @(posedge core_clk) disable iff (rst)
      (hostWr && hostSel == CAAE_SEL_AGECMD) |=> manPend_r;
   endproperty
   a_manual: assert property (p_manual) else $error("age command lost");

   property p_interval;
      @(posedge core_clk) disable iff (rst)
      (autoEn && intervalCnt_r == 32'h0000_0001 && !hostWr) |=>
         (autoPend_r && intervalCnt_r == intervalReg_r);
   endproperty
   a_interval: assert property (p_interval) else $error("interval not reloaded");

   property p_intervalRst;
      @(posedge core_clk) $past(rst) |-> (intervalReg_r == INTERVAL_RST);
   endproperty
   a_intervalRst: assert property (p_intervalRst) else $error("bad interval reset");

   property p_prio;
      @(posedge core_clk) disable iff (rst)
      (cfgReg_r[CAAE_CFG_PRIO_BIT] && agePend) |-> !portTake ##1 purgeDone_r;
   endproperty
   a_prio: assert property (p_prio) else $error("port beat aging");

   property p_lifeRst;
      @(posedge core_clk) $past(rst) |-> (lifeReg_r == CAAE_LIFE_RST);
   endproperty
   a_lifeRst: assert property (p_lifeRst) else $error("bad life reset");

   property p_stall;
      @(posedge core_clk) disable iff (rst)
      (portReq.req && !agePend && !portGrant_r) |=> portGrant_r;
   endproperty
   a_stall: assert property (p_stall) else $error("port request lost");

   property p_aging;
      @(posedge core_clk) disable iff (rst)
      (agePend && !cfgReg_r[CAAE_CFG_PRIO_BIT] && !portReq.req) |=> purgeDone_r;
   endproperty
   a_aging: assert property (p_aging) else $error("aging pass lost");

   c_auto:   cover property (@(posedge core_clk) disable iff (rst) doAuto);
   c_manual: cover property (@(posedge core_clk) disable iff (rst) doManual && !autoEn);
   c_stall:  cover property (@(posedge core_clk) disable iff (rst) portReq.req && agingWins);
endmodule : caae_aging_engine

// ===== dv/caae_host_model.sv
// host processor model driving the register access port
`timescale 1ns/100ps
module caae_host_model
   import caae_pkg::*;
(
   input  wire logic                core_clk, // system clock
   output caae_pkg::caae_host_req_t hostReq,  // register access
   input  wire logic [31:0]         rdData,   // read data from block
   input  wire logic                ready     // access done pulse
);
   // idle bus at start
   initial hostReq = '0;

   // one access: strobe for one edge, answer taken a cycle later
   // config writes come only from here
   task automatic access(input logic wr, input logic [5:0] sel, input logic [31:0] wd,
                         output logic [31:0] rd, output logic rdy);
      @(posedge core_clk);
      #1 hostReq = '{1'b1, wr, sel, wd};
      @(posedge core_clk);
      #1 rd = rdData;
      rdy = ready;
      // released lines flip so stale values never look valid
      hostReq = '{1'b0, 1'b0, ~sel, ~wd};
   endtask : access
endmodule : caae_host_model

// ===== dv/caae_aging_engine_tb.sv
// self-checking bench for the table entry aging engine
`timescale 1ns/100ps
module caae_aging_engine_tb;
   import caae_pkg::*;
   localparam int  NE = 16;            // table depth under test
   logic           core_clk;           // system clock
   logic           rst;                // sync reset
   caae_host_req_t hostReq;            // host access
   caae_port_req_t portReq;            // table operation
   logic [31:0]    hostRdData;         // host read data
   logic           hostReady;          // host done pulse
   logic           portGrant;          // op taken pulse
   logic           purgeDone;          // aging pass pulse
   logic [NE-1:0]  entryValid;         // per-entry valid
   logic [31:0]    cfgS, intvS, rdv;   // shadows and read value
   logic [8:0]     lifeS;              // life shadow
   logic           rdy;                // ready seen
   integer         seed, errors, testsRun, n;

   caae_aging_engine #(.ENTRIES(NE), .INTERVAL_RST(CAAE_INTERVAL_RST)) i_dut (
      .core_clk(core_clk), .rst(rst), .hostReq(hostReq), .hostRdData_r(hostRdData),
      .hostPortReady_r(hostReady), .portReq(portReq), .portGrant_r(portGrant),
      .purgeDone_r(purgeDone), .entryValid_r(entryValid));
   caae_host_model i_host (.core_clk(core_clk), .hostReq(hostReq), .rdData(hostRdData), .ready(hostReady));

   // free running 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // expected read value from shadows; stamps never readable
   function automatic logic [31:0] expRead(input logic [4:0] w);
      case (w)
         CAAE_SEL_CONFIG:   return cfgS;
         CAAE_SEL_INTERVAL: return intvS;
         CAAE_SEL_LIFE:     return {23'h0, lifeS};
         default:           return 32'h0;
      endcase
   endfunction : expRead

   // host write, select bit 0 random since it is ignored
   task automatic hostWr(input logic [4:0] w, input logic [31:0] d);
      i_host.access(1'b1, {w, seed[3]}, d, rdv, rdy);
      check("write ready", {31'h0, rdy}, 32'h1);
      if (w == CAAE_SEL_CONFIG) cfgS = d;
      if (w == CAAE_SEL_INTERVAL) intvS = d;
      if (w == CAAE_SEL_LIFE) lifeS = d[8:0];
   endtask : hostWr

   // read every select, including unmapped ones
   task automatic readAll;
      for (int w = 0; w < 32; w++) begin
         i_host.access(1'b0, {w[4:0], seed[5]}, 32'h0, rdv, rdy);
         check("register read", rdv, expRead(w[4:0]));
      end
   endtask : readAll

   // table op held until granted, dropped in the grant cycle
   task automatic portOp(input logic lrn, input logic pm, input logic [7:0] ix);
      int k;
      @(posedge core_clk);
      #1 portReq = '{1'b1, lrn, pm, ix};
      k = 0;
      do begin
         @(posedge core_clk);
         #1 k++;
      end while (portGrant !== 1'b1 && k < 8);
      portReq = '{1'b0, 1'b0, 1'b0, ~ix};
      check("grant wait within 3", {31'h0, k <= 3}, 32'h1);
      // a granted learn must leave its entry valid
      if (lrn) check("valid after grant", {31'h0, entryValid[ix]}, 32'h1);
   endtask : portOp

   // cycles until the next aging pass pulse, bounded
   task automatic waitPurge(output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         #1 c++;
      end while (purgeDone !== 1'b1 && c < 300);
   endtask : waitPurge

   // one place where the run ends
   task automatic printVerdict;
      $display("comparisons %0d mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : printVerdict

   // watchdog well beyond the expected run
   initial begin
      #100000;
      errors++;
      printVerdict;
   end

   // main sequence
   initial begin
      seed = 32'h537a;
      errors = 0;
      testsRun = 0;
      rst = 1'b1;
      portReq = '0;
      cfgS = CAAE_CONFIG_RST;
      intvS = CAAE_INTERVAL_RST;
      lifeS = CAAE_LIFE_RST;
      repeat (3) @(posedge core_clk);
      #1 rst = 1'b0;
      // reset values and hidden stamps
      readAll;
      hostWr(CAAE_SEL_LIFE, 32'hffff_ffff);
      hostWr(CAAE_SEL_INTERVAL, $random(seed));
      hostWr(5'h05, 32'hdead_beef);
      readAll;
      $display("test registers done");
      // manual aging with auto off: oldest life removed first, permanent kept
      hostWr(CAAE_SEL_LIFE, 32'h5);
      portOp(1'b1, 1'b1, 8'h0);
      portOp(1'b1, 1'b0, 8'h1);
      hostWr(CAAE_SEL_LIFE, 32'h4);
      portOp(1'b1, 1'b0, 8'h2);
      check("valid after learn", 32'(entryValid), 32'h7);
      for (int a = 0; a < 3; a++) begin
         hostWr(CAAE_SEL_AGECMD, $random(seed));
         repeat (4) @(posedge core_clk);
         check("valid after manual age", 32'(entryValid), a == 0 ? 32'h3 : 32'h1);
      end
      $display("test manual aging done");
      // automatic aging, interval spacing, refresh restarts life
      hostWr(CAAE_SEL_LIFE, 32'h3);
      hostWr(CAAE_SEL_INTERVAL, 32'ha);
      portOp(1'b1, 1'b0, 8'h1);
      portOp(1'b1, 1'b0, 8'h2);
      hostWr(CAAE_SEL_CONFIG, (32'h1 << CAAE_CFG_AUTO_BIT) | (32'(seed[1]) << CAAE_CFG_PRIO_BIT));
      waitPurge(n);
      check("first pass in time", {31'h0, n <= 12}, 32'h1);
      waitPurge(n);
      check("pass spacing", n, 32'ha);
      check("valid after two passes", 32'(entryValid), 32'h7);
      portOp(1'b0, 1'b0, 8'h1);
      waitPurge(n);
      check("valid after third pass", 32'(entryValid), 32'h3);
      waitPurge(n);
      waitPurge(n);
      check("valid after fifth pass", 32'(entryValid), 32'h1);
      $display("test auto aging done");
      // random traffic against aging, both precedence settings
      for (int p = 0; p < 2; p++) begin
         hostWr(CAAE_SEL_INTERVAL, 32'h3);
         hostWr(CAAE_SEL_CONFIG, (32'h1 << CAAE_CFG_AUTO_BIT) | (32'(p) << CAAE_CFG_PRIO_BIT));
         // ops stalled at most one pass
         repeat (16) begin
            repeat ($unsigned($random(seed)) % 4) @(posedge core_clk);
            portOp(seed[0], 1'b0, 8'($unsigned($random(seed)) % NE));
         end
      end
      $display("test arbitration done");
      // auto off: no passes at all
      hostWr(CAAE_SEL_CONFIG, 32'h0);
      repeat (3) @(posedge core_clk);
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         #1 if (purgeDone === 1'b1) n++;
      end
      check("passes with auto off", n, 32'h0);
      $display("test auto disable done");
      // reset in mid-run brings the registers back to their reset values
      rst = 1'b1;
      repeat (3) @(posedge core_clk);
      #1 rst = 1'b0;
      cfgS = CAAE_CONFIG_RST;
      intvS = CAAE_INTERVAL_RST;
      lifeS = CAAE_LIFE_RST;
      readAll;
      $display("test mid-run reset done");
      printVerdict;
   end
endmodule : caae_aging_engine_tb
